// ---- hw/edge_sync.sv ----
// Two-flop synchroniser with level, rising-edge and falling-edge outputs.
`timescale 1ns/10ps
`include "synth_feature_map.svh"

module edge_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] hist_ff;

  // The first stage feeds only the second, so metastability cannot spread.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= {W{`SYNC_RESET_LEVEL}};
      sync_ff <= {W{`SYNC_RESET_LEVEL}};
      hist_ff <= {W{`SYNC_RESET_LEVEL}};
    end else begin
      meta_ff <= pinIn;
      sync_ff <= meta_ff;
      hist_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise = sync_ff & ~hist_ff;
  assign fall = ~sync_ff & hist_ff;

endmodule

// ---- hw/synth_feature_ctrl_phase_detect.sv ----
// Feature-control register and phase-frequency detector of the synthesizer.
`timescale 1ns/10ps
`include "synth_feature_map.svh"

module synth_feature_ctrl_phase_detect (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [`FEAT_WIDTH-1:0] dataBus,
  input wire logic enhWriteStrobe,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic serialWrite,
  input wire logic busMode,
  input wire logic serialMode,
  input wire logic enhEnableN,
  input wire logic dividedVco,
  input wire logic dividedReference,
  input wire logic modulusSelect,
  input wire logic prescalerOut,
  output logic pumpUpN,
  output logic pumpDownN,
  output logic lockFilter,
  output logic lockIndicatorOut,
  output logic lockIndicatorOe,
  output logic diagOut,
  output logic dividedVcoOut,
  output logic dividedReferenceOut,
  output logic powerDown,
  output logic counterLoad,
  output synth_feature_pkg::loadSource_t counterLoadSource
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  synth_feature_pkg::pins_t pinRaw;
  synth_feature_pkg::pins_t lvl;
  synth_feature_pkg::pins_t rise;
  synth_feature_pkg::pins_t fall;
  logic [`FEAT_WIDTH-1:0] dataLvl;

  assign pinRaw = {enhWriteStrobe, serialClk, serialData, serialWrite, dividedVco, dividedReference,
                   modulusSelect, prescalerOut, enhEnableN, busMode, serialMode};

  edge_sync #(
    .W($bits(synth_feature_pkg::pins_t))
  ) ctrlSync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(pinRaw),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // Data travels through the same depth as the strobe, so it lines up with its edge.
  edge_sync #(
    .W(`FEAT_WIDTH)
  ) dataSync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(dataBus),
    .level(dataLvl),
    .rise(),
    .fall()
  );

  // ****************************************************************
  // Programming port
  // ****************************************************************
  synth_feature_pkg::feature_t feat_ff;
  synth_feature_pkg::feature_t nxt_feat;
  logic [`FEAT_WIDTH-1:0] shift_ff;
  logic [`FEAT_WIDTH-1:0] nxt_shift;

  // The port keeps working under power-down so software can wake the part.
  always_comb begin
    nxt_feat = feat_ff;
    nxt_shift = shift_ff;
    if (lvl.serialMode) begin
      if (rise.serialClk && lvl.enhStrobe && !lvl.serialWrite) begin
        nxt_shift = {shift_ff[`FEAT_WIDTH-2:0], lvl.serialData};
      end
      if (fall.enhStrobe) begin
        nxt_feat = shift_ff;
      end
    end else if (rise.enhStrobe) begin
      nxt_feat = dataLvl;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      feat_ff <= `FEAT_RESET_VALUE;
      shift_ff <= `FEAT_RESET_VALUE;
    end else begin
      feat_ff <= nxt_feat;
      shift_ff <= nxt_shift;
    end
  end

  // ****************************************************************
  // Effective feature bits
  // ****************************************************************
  synth_feature_pkg::feature_t eff;
  logic halt;

  // Reserved bits are carried but drive nothing.
  assign eff = lvl.enhEnableN ? synth_feature_pkg::feature_t'(`FEAT_RESET_VALUE) : feat_ff;
  assign halt = eff.powerDown;

  // ****************************************************************
  // Control and diagnostic outputs
  // ****************************************************************
  logic diag_ff;
  logic nxt_diag;
  logic vcoOut_ff;
  logic nxt_vcoOut;
  logic refOut_ff;
  logic nxt_refOut;
  logic load_ff;
  logic nxt_load;
  logic pd_ff;
  synth_feature_pkg::loadSource_t src_ff;
  synth_feature_pkg::loadSource_t nxt_src;

  // When both monitor bits are set the synchronised prescaler output takes the pin.
  always_comb begin
    nxt_diag = 1'b0;
    if (!halt) begin
      if (eff.prescMonitor) begin
        nxt_diag = lvl.presc;
      end else if (eff.modSelMonitor) begin
        nxt_diag = lvl.modSel;
      end
    end
    nxt_vcoOut = lvl.vco && !eff.outputOff && !halt;
    nxt_refOut = lvl.refer && !eff.outputOff && !halt;
    nxt_load = eff.counterLoad && !halt;
    if (lvl.busMode) begin
      nxt_src = synth_feature_pkg::SRC_DIRECT;
    end else if (lvl.serialMode) begin
      nxt_src = synth_feature_pkg::SRC_SERIAL;
    end else begin
      nxt_src = synth_feature_pkg::SRC_PARALLEL;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_ff <= 1'b0;
      vcoOut_ff <= 1'b0;
      refOut_ff <= 1'b0;
      load_ff <= 1'b0;
      pd_ff <= 1'b0;
      src_ff <= synth_feature_pkg::SRC_PARALLEL;
    end else begin
      diag_ff <= nxt_diag;
      vcoOut_ff <= nxt_vcoOut;
      refOut_ff <= nxt_refOut;
      load_ff <= nxt_load;
      pd_ff <= halt;
      src_ff <= nxt_src;
    end
  end

  assign diagOut = diag_ff;
  assign dividedVcoOut = vcoOut_ff;
  assign dividedReferenceOut = refOut_ff;
  assign counterLoad = load_ff;
  assign powerDown = pd_ff;
  assign counterLoadSource = src_ff;

  // ****************************************************************
  // Phase-frequency detector
  // ****************************************************************
  synth_feature_pkg::pfdState_t pfd_ff;
  synth_feature_pkg::pfdState_t nxt_pfd;
  logic upN_ff;
  logic dnN_ff;
  logic filt_ff;
  logic lockOe_ff;
  logic vcoRise;
  logic refRise;

  // Edges are resolved to one clock period; finer offsets are lost.
  assign vcoRise = rise.vco;
  assign refRise = rise.refer;

  always_comb begin
    nxt_pfd = pfd_ff;
    if (halt) begin
      nxt_pfd = synth_feature_pkg::PFD_IDLE;
    end else begin
      case (pfd_ff)
        synth_feature_pkg::PFD_IDLE: begin
          if (refRise && !vcoRise) begin
            nxt_pfd = synth_feature_pkg::PFD_UP;
          end else if (vcoRise && !refRise) begin
            nxt_pfd = synth_feature_pkg::PFD_DOWN;
          end
        end
        synth_feature_pkg::PFD_UP: begin
          if (vcoRise) begin
            nxt_pfd = refRise ? synth_feature_pkg::PFD_UP : synth_feature_pkg::PFD_IDLE;
          end
        end
        synth_feature_pkg::PFD_DOWN: begin
          if (refRise) begin
            nxt_pfd = vcoRise ? synth_feature_pkg::PFD_DOWN : synth_feature_pkg::PFD_IDLE;
          end
        end
        default: begin
          nxt_pfd = synth_feature_pkg::PFD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pfd_ff <= synth_feature_pkg::PFD_IDLE;
      upN_ff <= 1'b1;
      dnN_ff <= 1'b1;
      filt_ff <= 1'b0;
      lockOe_ff <= 1'b0;
    end else begin
      pfd_ff <= nxt_pfd;
      upN_ff <= (nxt_pfd != synth_feature_pkg::PFD_UP);
      dnN_ff <= (nxt_pfd != synth_feature_pkg::PFD_DOWN);
      filt_ff <= (nxt_pfd != synth_feature_pkg::PFD_IDLE);
      lockOe_ff <= (nxt_pfd != synth_feature_pkg::PFD_IDLE);
    end
  end

  assign pumpUpN = upN_ff;
  assign pumpDownN = dnN_ff;
  assign lockFilter = filt_ff;
  // The open-drain pin only ever pulls low; the pull-up sits off chip.
  assign lockIndicatorOut = 1'b0;
  assign lockIndicatorOe = lockOe_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_pumps_exclusive;
    @(posedge ref_clk) disable iff (!rst_n)
    !(!pumpUpN && !pumpDownN);
  endproperty
  a_pumps_exclusive: assert property (p_pumps_exclusive) else $error("Both pumps active together.");
  property p_ref_leads;
    @(posedge ref_clk) disable iff (!rst_n)
    (pfd_ff == synth_feature_pkg::PFD_IDLE && refRise && !vcoRise && !halt) |=> (!pumpUpN && pumpDownN);
  endproperty
  a_ref_leads: assert property (p_ref_leads) else $error("Reference lead did not start pump up.");
  property p_vco_leads;
    @(posedge ref_clk) disable iff (!rst_n)
    (pfd_ff == synth_feature_pkg::PFD_IDLE && vcoRise && !refRise && !halt) |=> (!pumpDownN && pumpUpN);
  endproperty
  a_vco_leads: assert property (p_vco_leads) else $error("VCO lead did not start pump down.");
  property p_width;
    @(posedge ref_clk) disable iff (!rst_n)
    (!pumpUpN && !vcoRise && !halt) |=> !pumpUpN;
  endproperty
  a_width: assert property (p_width) else $error("Pump up ended before the VCO edge.");
  property p_edges_only;
    @(posedge ref_clk) disable iff (!rst_n)
    (pumpUpN && pumpDownN && !vcoRise && !refRise) |=> (pumpUpN && pumpDownN);
  endproperty
  a_edges_only: assert property (p_edges_only) else $error("Pump started without an edge.");
  property p_lock_nand;
    @(posedge ref_clk) disable iff (!rst_n)
    lockFilter == !(pumpUpN && pumpDownN);
  endproperty
  a_lock_nand: assert property (p_lock_nand) else $error("Lock filter is not the pump NAND.");
  property p_lock_od;
    @(posedge ref_clk) disable iff (!rst_n)
    (lockIndicatorOe == !(pumpUpN && pumpDownN)) && !lockIndicatorOut;
  endproperty
  a_lock_od: assert property (p_lock_od) else $error("Lock indicator is not the pump AND.");
  property p_halt;
    @(posedge ref_clk) disable iff (!rst_n)
    halt |=> (pumpUpN && pumpDownN && !diagOut && !counterLoad && !dividedVcoOut && powerDown);
  endproperty
  a_halt: assert property (p_halt) else $error("Power-down left a function running.");
  property p_parallel;
    @(posedge ref_clk) disable iff (!rst_n)
    (rise.enhStrobe && !lvl.serialMode) |=> (feat_ff == $past(dataLvl));
  endproperty
  a_parallel: assert property (p_parallel) else $error("Parallel write not captured.");
  property p_serial;
    @(posedge ref_clk) disable iff (!rst_n)
    (fall.enhStrobe && lvl.serialMode) |=> (feat_ff == $past(shift_ff));
  endproperty
  a_serial: assert property (p_serial) else $error("Serial word not captured.");
  property p_enable_gate;
    @(posedge ref_clk) disable iff (!rst_n)
    lvl.enhEnableN |=> (!counterLoad && !powerDown && !diagOut);
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("Feature bits acted while disabled.");
  property p_outputs_off;
    @(posedge ref_clk) disable iff (!rst_n)
    eff.outputOff |=> (!dividedVcoOut && !dividedReferenceOut);
  endproperty
  a_outputs_off: assert property (p_outputs_off) else $error("Divided outputs not disabled.");
  property p_load;
    @(posedge ref_clk) disable iff (!rst_n)
    (eff.counterLoad && !halt) |=> counterLoad;
  endproperty
  a_load: assert property (p_load) else $error("Counter load not asserted.");

endmodule

// ---- hw/synth_feature_map.svh ----
// Bit positions, widths and reset values of the feature-control block.
`ifndef SYNTH_FEATURE_MAP_SVH
`define SYNTH_FEATURE_MAP_SVH

// ****************************************************************
// Feature-control register layout
// ****************************************************************
`define FEAT_WIDTH 8
`define FEAT_RESV_LSB 0
`define FEAT_RESV_MSB 2
`define FEAT_POWER_DOWN_BIT 3
`define FEAT_COUNTER_LOAD_BIT 4
`define FEAT_MODSEL_MONITOR_BIT 5
`define FEAT_PRESC_MONITOR_BIT 6
`define FEAT_OUTPUT_OFF_BIT 7
`define FEAT_RESET_VALUE 8'h00

// ****************************************************************
// Synchroniser
// ****************************************************************
`define SYNC_RESET_LEVEL 1'b0

`endif

// ---- hw/synth_feature_pkg.sv ----
// Types shared by the feature-control and phase-detector design.
package synth_feature_pkg;

  // ****************************************************************
  // Feature-control register, bit 7 down to bit 0
  // ****************************************************************
  typedef struct packed {
    logic outputOff;
    logic prescMonitor;
    logic modSelMonitor;
    logic counterLoad;
    logic powerDown;
    logic [2:0] reserved;
  } feature_t;

  // ****************************************************************
  // Pins that arrive from outside the clock domain
  // ****************************************************************
  typedef struct packed {
    logic enhStrobe;
    logic serialClk;
    logic serialData;
    logic serialWrite;
    logic vco;
    logic refer;
    logic modSel;
    logic presc;
    logic enhEnableN;
    logic busMode;
    logic serialMode;
  } pins_t;

  typedef enum logic [1:0] {
    SRC_PARALLEL,
    SRC_SERIAL,
    SRC_DIRECT
  } loadSource_t;

  typedef enum logic [1:0] {
    PFD_IDLE,
    PFD_UP,
    PFD_DOWN
  } pfdState_t;

endpackage

// ---- verification/loop_partner.sv ----
// Model of the loop side: divided clock sources and the pulled-up lock pin.
`timescale 1ns/10ps

module loop_partner (
  input wire logic ref_clk,
  input wire logic lockIndicatorOut,
  input wire logic lockIndicatorOe,
  output logic dividedVco,
  output logic dividedReference,
  output wire logic lockPin
);
  // ****************************************************************
  // Lock pin with external pull-up
  // ****************************************************************
  // The open-drain pin only pulls low, so the released level comes from the pull-up.
  assign lockPin = lockIndicatorOe ? lockIndicatorOut : 1'b1;

  initial begin
    dividedVco = 1'b0;
    dividedReference = 1'b0;
  end

  task automatic setLvl(input logic v, input logic r);
    @(negedge ref_clk);
    dividedVco = v;
    dividedReference = r;
    repeat (4) @(negedge ref_clk);
  endtask

  // Falls come lagging input first, so a detector acting on falls would pulse the other pump.
  task automatic pair(input logic vcoFirst, input int off);
    @(negedge ref_clk);
    if (vcoFirst) dividedVco = 1'b1;
    else dividedReference = 1'b1;
    repeat (off) @(negedge ref_clk);
    dividedVco = 1'b1;
    dividedReference = 1'b1;
    repeat (8) @(negedge ref_clk);
    if (vcoFirst) dividedReference = 1'b0;
    else dividedVco = 1'b0;
    repeat (off) @(negedge ref_clk);
    dividedVco = 1'b0;
    dividedReference = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule

// ---- verification/tb_synth_feature_ctrl_phase_detect.sv ----
// Self-checking testbench of the feature-control register and phase detector.
`timescale 1ns/10ps

module tb_synth_feature_ctrl_phase_detect;
  logic ref_clk;
  logic rst_n;
  logic [7:0] dataBus;
  logic enhWriteStrobe, serialClk, serialData, serialWrite, busMode, serialMode, enhEnableN;
  logic modulusSelect, prescalerOut;
  logic dividedVco, dividedReference, lockPin;
  logic pumpUpN, pumpDownN, lockFilter, lockIndicatorOut, lockIndicatorOe, diagOut;
  logic dividedVcoOut, dividedReferenceOut, powerDown, counterLoad;
  synth_feature_pkg::loadSource_t counterLoadSource;
  logic [10:0] stat;
  int errorCnt = 0;
  int testsRun = 0;
  int upCnt, dnCnt, cyc;
  int lockBad = 0;

  assign stat = {pumpUpN, pumpDownN, lockFilter, lockIndicatorOe, diagOut, dividedVcoOut,
                 dividedReferenceOut, powerDown, counterLoad, counterLoadSource};

  synth_feature_ctrl_phase_detect uut (.ref_clk(ref_clk), .rst_n(rst_n), .dataBus(dataBus),
    .enhWriteStrobe(enhWriteStrobe), .serialClk(serialClk), .serialData(serialData),
    .serialWrite(serialWrite), .busMode(busMode), .serialMode(serialMode), .enhEnableN(enhEnableN),
    .dividedVco(dividedVco), .dividedReference(dividedReference), .modulusSelect(modulusSelect),
    .prescalerOut(prescalerOut), .pumpUpN(pumpUpN), .pumpDownN(pumpDownN), .lockFilter(lockFilter),
    .lockIndicatorOut(lockIndicatorOut), .lockIndicatorOe(lockIndicatorOe), .diagOut(diagOut),
    .dividedVcoOut(dividedVcoOut), .dividedReferenceOut(dividedReferenceOut),
    .powerDown(powerDown), .counterLoad(counterLoad), .counterLoadSource(counterLoadSource));

  loop_partner partner (.ref_clk(ref_clk), .lockIndicatorOut(lockIndicatorOut),
    .lockIndicatorOe(lockIndicatorOe), .dividedVco(dividedVco), .dividedReference(dividedReference),
    .lockPin(lockPin));

  // ****************************************************************
  // Clock, monitors and closing report
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(negedge ref_clk) begin
    if (rst_n) begin
      if (pumpUpN === 1'b0) upCnt++;
      if (pumpDownN === 1'b0) dnCnt++;
      if (lockPin !== (pumpUpN & pumpDownN) || lockFilter !== ~(pumpUpN & pumpDownN)) lockBad++;
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Checks run: %0d, mismatches: %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errorCnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic waitN(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // ****************************************************************
  // Programming port and detector tasks
  // ****************************************************************
  // Pins are synchronised, so every level is held well beyond the two-cycle latency.
  task automatic wr(input logic [7:0] v);
    @(negedge ref_clk);
    dataBus = v;
    waitN(4);
    enhWriteStrobe = 1'b1;
    waitN(5);
    enhWriteStrobe = 1'b0;
    waitN(8);
  endtask

  task automatic swr(input logic [7:0] v);
    @(negedge ref_clk);
    enhWriteStrobe = 1'b1;
    waitN(4);
    for (int i = 7; i >= 0; i--) begin
      serialData = v[i];
      waitN(4);
      serialClk = 1'b1;
      waitN(4);
      serialClk = 1'b0;
      waitN(4);
    end
    enhWriteStrobe = 1'b0;
    waitN(8);
  endtask

  task automatic pumpT(input logic vcoFirst, input int off, input int on);
    upCnt = 0;
    dnCnt = 0;
    partner.pair(vcoFirst, off);
    chk(upCnt, vcoFirst ? 0 : off * on);
    chk(dnCnt, vcoFirst ? off * on : 0);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {dataBus, enhWriteStrobe, serialClk, serialData, serialWrite, busMode, serialMode} = '0;
    {modulusSelect, prescalerOut, enhEnableN} = '0;
    rst_n = 1'b0;
    waitN(16);
    rst_n = 1'b1;
    waitN(4);
    chk(stat, 11'h600);
    wr(8'h10);
    chk(stat, 11'h604);
    busMode = 1'b1;
    waitN(6);
    chk(stat, 11'h606);
    busMode = 1'b0;
    enhEnableN = 1'b1;
    waitN(6);
    chk(stat, 11'h600);
    enhEnableN = 1'b0;
    wr(8'h20);
    modulusSelect = 1'b1;
    waitN(6);
    chk(stat, 11'h640);
    modulusSelect = 1'b0;
    waitN(6);
    chk(stat, 11'h600);
    wr(8'h60);
    prescalerOut = 1'b1;
    waitN(6);
    chk(stat, 11'h640);
    prescalerOut = 1'b0;
    modulusSelect = 1'b1;
    waitN(6);
    chk(stat, 11'h600);
    wr(8'h00);
    partner.setLvl(1'b1, 1'b1);
    chk(stat, 11'h630);
    wr(8'h80);
    chk(stat, 11'h600);
    wr(8'h00);
    partner.setLvl(1'b0, 1'b0);
    pumpT(1'b0, 10, 1);
    pumpT(1'b0, 20, 1);
    pumpT(1'b1, 7, 1);
    wr(8'h18);
    chk(stat, 11'h608);
    pumpT(1'b0, 10, 0);
    wr(8'h10);
    chk(stat, 11'h604);
    serialMode = 1'b1;
    swr(8'h30);
    chk(stat, 11'h645);
    serialWrite = 1'b1;
    swr(8'hff);
    chk(stat, 11'h645);
    serialWrite = 1'b0;
    swr(8'h00);
    chk(stat, 11'h601);
    chk(lockBad, 0);
    summarize();
  end
endmodule
